// ==== design/fpga_config_manager.v ====
// Purpose: load and reload the main FPGA while staying visible on PCIe
// Assumes: all inputs synchronous to i_sys_clk; flash and config port
//          handshake by strobe/ready
// Notes: config space and device id held here, never touched by a load
//
// How it works
// RULE_01 - PCIe target ready immediately after reset
// RULE_02 - Four image slots in configuration flash
// RULE_03 - Flash writable from JTAG or PCIe
// RULE_04 - Power-up image chosen by hardware switch
// RULE_05 - Host selects image, then reload command
// RULE_06 - Stream image from host straight to FPGA
// RULE_07 - JTAG load allowed, manager handshakes it
// RULE_08 - PCIe config space kept across reloads
// RULE_09 - Same device id after reload
// RULE_10 - Gate user traffic while loading; report done
`timescale 1ns/1ps
`include "cfg_mgr_regs.vh"

module fpga_config_manager #(
  parameter [31:0] ENUM_CYC = `ENUM_WINDOW_CYC
) (
  input wire i_sys_clk,
  input wire i_nrst,
  input wire [`IMG_SEL_W-1:0] i_boot_switch,
  input wire [`IMG_SEL_W-1:0] i_host_img_sel,
  input wire i_host_reload,
  input wire i_host_stream_start,
  input wire i_stream_valid,
  input wire [7:0] i_stream_data,
  input wire i_stream_last,
  input wire i_jtag_active,
  input wire i_jtag_flash_we,
  input wire i_host_flash_we,
  input wire [`FLASH_AW-1:0] i_flash_wr_addr,
  input wire [7:0] i_flash_wr_data,
  input wire i_flash_rd_valid,
  input wire [7:0] i_flash_rd_data,
  input wire i_flash_rd_last,
  input wire i_cfg_ready,
  input wire i_cfg_done,
  input wire i_cfgspace_we,
  input wire [5:0] i_cfgspace_addr,
  input wire [31:0] i_cfgspace_wdata,
  output reg o_pcie_target_en,
  output reg [15:0] o_dev_id,
  output reg [31:0] o_cfgspace_rdata,
  output reg o_flash_rd_req,
  output reg [`IMG_SEL_W-1:0] o_flash_img,
  output reg o_flash_we,
  output reg [`IMG_SEL_W+`FLASH_AW-1:0] o_flash_waddr,
  output reg [7:0] o_flash_wdata,
  output reg o_cfg_prog_n,
  output reg o_cfg_valid,
  output reg [7:0] o_cfg_data,
  output reg o_stream_ready,
  output reg o_jtag_grant,
  output reg o_user_gate,
  output reg o_load_done,
  output reg o_loading,
  output reg [1:0] o_load_src,
  output reg [`IMG_SEL_W-1:0] o_active_img
);

  // ----------------------------------------------------------------
  // State codes, one-hot
  // ----------------------------------------------------------------
  localparam [4:0] ST_BOOT = 5'h01;
  localparam [4:0] ST_PROG = 5'h02;
  localparam [4:0] ST_LOAD = 5'h04;
  localparam [4:0] ST_WAIT = 5'h08;
  localparam [4:0] ST_IDLE = 5'h10;

  reg [4:0] state;
  reg [1:0] src;
  reg [`IMG_SEL_W-1:0] img;
  reg [31:0] enum_cnt;
  // Config space lives outside the FPGA load path so it survives it
  reg [31:0] cfgspace [0:63];

  // ----------------------------------------------------------------
  // Preserved configuration space
  // ----------------------------------------------------------------
  // Written only by the host; a reload never clears it
  always @(posedge i_sys_clk) begin
    if (i_cfgspace_we) begin
      cfgspace[i_cfgspace_addr] <= i_cfgspace_wdata; // RULE_08
    end
  end

  // Registered read, no reset on the array itself
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cfgspace_rdata <= 32'h0000_0000;
    end else begin
      o_cfgspace_rdata <= cfgspace[i_cfgspace_addr]; // RULE_08
    end
  end

  // ----------------------------------------------------------------
  // Flash programming path
  // ----------------------------------------------------------------
  // JTAG and host strobes are ORed, writes pass only in idle; a write lands in the slot chosen by host select
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_flash_we <= 1'b0;
      o_flash_waddr <= {(`IMG_SEL_W+`FLASH_AW){1'b0}};
      o_flash_wdata <= 8'h00;
    end else begin
      o_flash_we <= (i_jtag_flash_we | i_host_flash_we) & (state == ST_IDLE); // RULE_03
      o_flash_waddr <= {i_host_img_sel, i_flash_wr_addr}; // RULE_02
      o_flash_wdata <= i_flash_wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Load sequencer
  // ----------------------------------------------------------------
  // Target comes up on the first edge; the FPGA load runs behind it
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= ST_BOOT;
      src <= `SRC_FLASH;
      img <= {`IMG_SEL_W{1'b0}};
      enum_cnt <= 32'h0000_0000;
      o_pcie_target_en <= 1'b0;
      o_dev_id <= `DEV_ID_DEFAULT;
      o_flash_rd_req <= 1'b0;
      o_flash_img <= {`IMG_SEL_W{1'b0}};
      o_cfg_prog_n <= 1'b1;
      o_cfg_valid <= 1'b0;
      o_cfg_data <= 8'h00;
      o_stream_ready <= 1'b0;
      o_jtag_grant <= 1'b0;
      o_user_gate <= 1'b1;
      o_load_done <= 1'b0;
      o_loading <= 1'b0;
      o_load_src <= `SRC_FLASH;
      o_active_img <= {`IMG_SEL_W{1'b0}};
    end else begin
      o_pcie_target_en <= 1'b1; // RULE_01
      o_dev_id <= o_dev_id; // RULE_09
      o_cfg_valid <= 1'b0;
      // Count load cycles, holding once the enumeration window count is reached
      if (o_loading && enum_cnt < ENUM_CYC) begin
        enum_cnt <= enum_cnt + 32'h1;
      end
      case (state)
        ST_BOOT: begin
          img <= i_boot_switch; // RULE_04
          src <= `SRC_FLASH;
          o_cfg_prog_n <= 1'b0;
          o_loading <= 1'b1;
          o_user_gate <= 1'b1; // RULE_10
          state <= ST_PROG;
        end
        ST_PROG: begin
          // One cycle of program pulse clears the FPGA
          o_cfg_prog_n <= 1'b1;
          o_load_src <= src;
          o_flash_img <= img;
          o_flash_rd_req <= (src == `SRC_FLASH);
          o_stream_ready <= (src == `SRC_STREAM) & i_cfg_ready; // RULE_06
          o_jtag_grant <= (src == `SRC_JTAG); // RULE_07
          state <= (src == `SRC_JTAG) ? ST_WAIT : ST_LOAD;
        end
        ST_LOAD: begin
          // Stall source when the config port is not ready
          o_stream_ready <= (src == `SRC_STREAM) & i_cfg_ready;
          if (src == `SRC_FLASH && i_flash_rd_valid && i_cfg_ready) begin
            o_cfg_valid <= 1'b1;
            o_cfg_data <= i_flash_rd_data;
            if (i_flash_rd_last) begin
              o_flash_rd_req <= 1'b0;
              state <= ST_WAIT;
            end
          end else if (src == `SRC_STREAM && i_stream_valid && o_stream_ready) begin
            o_cfg_valid <= 1'b1; // RULE_06
            o_cfg_data <= i_stream_data;
            if (i_stream_last) begin
              o_stream_ready <= 1'b0;
              state <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          // JTAG loads finish when the tool drops its request and FPGA is done
          if (i_cfg_done && (src != `SRC_JTAG || !i_jtag_active)) begin
            o_jtag_grant <= 1'b0;
            o_loading <= 1'b0;
            o_load_done <= 1'b1; // RULE_10
            o_user_gate <= 1'b0; // RULE_10
            o_active_img <= img;
            enum_cnt <= 32'h0000_0000;
            state <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          // Reload, stream and JTAG requests in that priority
          if (i_host_reload || i_host_stream_start || i_jtag_active) begin
            o_load_done <= 1'b0;
            o_loading <= 1'b1;
            o_user_gate <= 1'b1; // RULE_10
            o_cfg_prog_n <= 1'b0;
            state <= ST_PROG;
            if (i_host_reload) begin
              src <= `SRC_FLASH;
              img <= i_host_img_sel; // RULE_05
            end else if (i_host_stream_start) begin
              src <= `SRC_STREAM;
            end else begin
              src <= `SRC_JTAG;
            end
          end
        end
        default: begin
          state <= ST_BOOT;
        end
      endcase
    end
  end

endmodule

// ==== include/cfg_mgr_regs.vh ====
// Purpose: constants for the FPGA configuration manager
// Assumes: 40 MHz system clock
// Notes: timing counts derived from times in their own units
`ifndef CFG_MGR_REGS_VH
`define CFG_MGR_REGS_VH

// Host enumeration window, milliseconds
`define ENUM_WINDOW_MS 100
`define CLK_KHZ 40000
// Cycles the target may take to appear; longest time, exact product, no rounding
`define ENUM_WINDOW_CYC (`ENUM_WINDOW_MS * `CLK_KHZ)
// Number of stored images and select width
`define IMG_COUNT 4
`define IMG_SEL_W 2
// Load source codes
`define SRC_FLASH 2'h0
`define SRC_STREAM 2'h1
`define SRC_JTAG 2'h2
// Flash address width per image slot
`define FLASH_AW 24
// Default device identity, value is arbitrary
`define DEV_ID_DEFAULT 16'h1234

`endif

// ==== tb/cfg_far_model.sv ====
// Purpose: flash and config port stand-in
// Assumes: four bytes an image
// Notes: data inverted while not valid
`timescale 1ns/1ps
module cfg_far_model (
  input wire i_sys_clk, i_nrst, i_slow, i_req, i_prog_n, i_valid, i_grant,
  input wire [1:0] i_img,
  output wire o_rd_valid, o_rd_last, o_ready, o_done,
  output wire [7:0] o_rd_data
);
  reg [2:0] sent;
  reg [2:0] seen;
  reg tick;
  // Slot in the data, so a wrong image shows
  assign o_rd_valid = i_req && sent < 3'h4;
  assign o_rd_data = {i_img, 3'h0, sent} ^ {8{!o_rd_valid}};
  assign o_rd_last = sent == 3'h3;
  assign o_ready = !i_slow || tick; // Stalls every other cycle when slow
  assign o_done = seen == 3'h4;
  // A program pulse restarts the image
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst || !i_prog_n) begin
      sent <= 3'h0;
      seen <= 3'h0;
      tick <= 1'h0;
    end else begin
      tick <= !tick;
      sent <= sent + {2'h0, o_rd_valid && o_ready};
      seen <= i_grant ? 3'h4 : seen + {2'h0, i_valid};
    end
  end
endmodule

// ==== tb/cfg_mgr_sva.sv ====
// Purpose: port checks for the config manager
// Assumes: idle means not loading
// Notes: bound from tb_top
`timescale 1ns/1ps
module cfg_mgr_sva (
  input wire i_sys_clk, i_nrst, i_host_flash_we, i_flash_rd_valid, i_cfg_ready,
  input wire [1:0] i_host_img_sel, o_load_src,
  input wire [23:0] i_flash_wr_addr,
  input wire [7:0] i_flash_rd_data, o_cfg_data,
  input wire o_pcie_target_en, o_flash_rd_req, o_flash_we, o_cfg_prog_n, o_cfg_valid,
  input wire o_jtag_grant, o_user_gate, o_load_done, o_loading,
  input wire [15:0] o_dev_id,
  input wire [25:0] o_flash_waddr
);
  // One clock domain, one default
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  property p_tgt; $past(i_nrst) |-> o_pcie_target_en; endproperty
  a_tgt: assert property (p_tgt) else $error("target gone");
  property p_id; $past(i_nrst, 2) |-> $stable(o_dev_id); endproperty
  a_id: assert property (p_id) else $error("id moved");
  property p_prog; $fell(o_cfg_prog_n) |=> o_cfg_prog_n && o_loading; endproperty
  a_prog: assert property (p_prog) else $error("bad prog");
  property p_gate; o_loading |-> o_user_gate; endproperty
  a_gate: assert property (p_gate) else $error("gate open");
  property p_done; $rose(o_load_done) |-> !o_loading && !o_user_gate; endproperty
  a_done: assert property (p_done) else $error("bad done");
  property p_byte; o_flash_rd_req && o_load_src == 2'h0 && i_flash_rd_valid && i_cfg_ready
    |=> o_cfg_valid && o_cfg_data == $past(i_flash_rd_data); endproperty
  a_byte: assert property (p_byte) else $error("byte lost");
  property p_jtag; o_jtag_grant |-> o_loading && o_load_src == 2'h2; endproperty
  a_jtag: assert property (p_jtag) else $error("bad grant");
  property p_fwe; i_host_flash_we && !o_loading |=> o_flash_we
    && o_flash_waddr == {$past(i_host_img_sel), $past(i_flash_wr_addr)}; endproperty
  a_fwe: assert property (p_fwe) else $error("bad write");
endmodule

// ==== tb/tb_top.sv ====
// Purpose: scenario bench for the config manager
// Assumes: partner gives four bytes a load
// Notes: short enumeration count
`timescale 1ns/1ps
`include "cfg_mgr_regs.vh"
module tb_top;
  logic i_sys_clk = 1'h0, i_nrst = 1'h0, i_host_reload = 1'h0, i_host_stream_start = 1'h0;
  logic i_stream_valid = 1'h0, i_stream_last = 1'h0, i_jtag_active = 1'h0, slow = 1'h0;
  logic i_host_flash_we = 1'h0, i_cfgspace_we = 1'h0, i_jtag_flash_we = 1'h0;
  logic i_flash_rd_valid, i_flash_rd_last, i_cfg_ready, i_cfg_done, o_pcie_target_en;
  logic o_flash_rd_req, o_flash_we, o_cfg_prog_n, o_cfg_valid, o_stream_ready;
  logic o_jtag_grant, o_user_gate, o_load_done, o_loading;
  logic [1:0] i_boot_switch = 2'h2, i_host_img_sel = 2'h3, o_flash_img, o_load_src;
  logic [1:0] o_active_img;
  logic [7:0] i_stream_data = 8'h0, i_flash_wr_data = 8'h5a, i_flash_rd_data;
  logic [7:0] o_flash_wdata, o_cfg_data;
  logic [15:0] o_dev_id;
  logic [23:0] i_flash_wr_addr = 24'habcd;
  logic [25:0] o_flash_waddr;
  logic [5:0] i_cfgspace_addr = 6'h5;
  logic [31:0] i_cfgspace_wdata = 32'hcafe0005, o_cfgspace_rdata;
  int err_total = 0, compares = 0;
  always #12.5 i_sys_clk = ~i_sys_clk;
  fpga_config_manager #(.ENUM_CYC(32'h10)) u_dut (.*);
  cfg_far_model u_far (.i_sys_clk, .i_nrst, .i_slow(slow), .i_req(o_flash_rd_req),
    .i_prog_n(o_cfg_prog_n), .i_valid(o_cfg_valid), .i_grant(o_jtag_grant),
    .i_img(o_flash_img), .o_rd_valid(i_flash_rd_valid), .o_rd_last(i_flash_rd_last),
    .o_ready(i_cfg_ready), .o_done(i_cfg_done), .o_rd_data(i_flash_rd_data));
  task chk(input string n, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task close_out;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Bounded wait for the load to finish
  task wt;
    repeat (2) @(posedge i_sys_clk);
    repeat (300) if (o_load_done !== 1'h1) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    chk("done", 1, o_load_done);
    chk("gate", 0, o_user_gate);
  endtask
  // Last byte of a flash image carries its slot in the top bits
  task t_boot;
    wt;
    chk("img", 2, o_active_img);
    chk("cfg data", 8'h83, o_cfg_data);
    chk("rd req", 0, o_flash_rd_req);
  endtask
  // Host write, then a JTAG write on the next edge
  task t_fwrite;
    @(posedge i_sys_clk);
    i_host_flash_we <= 1'h1;
    @(posedge i_sys_clk);
    {i_host_flash_we, i_jtag_flash_we} <= 2'h1;
    @(negedge i_sys_clk);
    chk("wdata", 8'h5a, o_flash_wdata);
    chk("waddr", 32'h0300abcd, o_flash_waddr);
    @(posedge i_sys_clk);
    i_jtag_flash_we <= 1'h0;
    @(negedge i_sys_clk);
    chk("jtag we", 1, o_flash_we);
  endtask
  // Stalling far side during a reload
  task t_reload;
    @(posedge i_sys_clk);
    {slow, i_cfgspace_we, i_host_reload} <= 3'h7;
    @(posedge i_sys_clk);
    {i_cfgspace_we, i_host_reload} <= 2'h0;
    @(negedge i_sys_clk);
    chk("gate on", 1, o_user_gate);
    wt;
    chk("img", 3, o_active_img);
    chk("flash img", 3, o_flash_img);
    chk("cfg data", 8'hc3, o_cfg_data);
    chk("id", `DEV_ID_DEFAULT, o_dev_id);
    chk("cspace", 32'hcafe0005, o_cfgspace_rdata);
    chk("tgt", 1, o_pcie_target_en);
  endtask
  task t_stream;
    @(posedge i_sys_clk);
    i_host_stream_start <= 1'h1;
    @(posedge i_sys_clk);
    i_host_stream_start <= 1'h0;
    for (int b = 0; b < 4; b++) begin
      {i_stream_valid, i_stream_last, i_stream_data} <= {1'h1, b == 3, 8'(b)};
      do @(negedge i_sys_clk); while (o_stream_ready !== 1'h1);
      @(posedge i_sys_clk);
    end
    {i_stream_valid, i_stream_last} <= 2'h0;
    wt;
    chk("src", 1, o_load_src);
    chk("cfg data", 8'h03, o_cfg_data);
    chk("sready", 0, o_stream_ready);
  endtask
  task t_jtag;
    @(posedge i_sys_clk);
    i_jtag_active <= 1'h1;
    repeat (4) @(negedge i_sys_clk);
    chk("grant", 1, o_jtag_grant);
    @(posedge i_sys_clk);
    i_jtag_active <= 1'h0;
    wt;
    chk("src", 2, o_load_src);
    chk("grant off", 0, o_jtag_grant);
  endtask
  initial begin
    repeat (4) @(posedge i_sys_clk);
    i_nrst <= 1'h1;
    t_boot;
    t_fwrite;
    t_reload;
    t_stream;
    t_jtag;
    close_out;
  end
  initial begin
    #90000;
    err_total++;
    close_out;
  end
endmodule
bind fpga_config_manager cfg_mgr_sva u_sva (.*);
